// file: dv/ssf_slave_model.sv
// behavioural serial slave facing the frame formatter
`timescale 1ns/1ps
module ssf_slave_model (
    input  wire logic        serialClockLine,
    input  wire logic        frameSelectLine,
    input  wire logic        serialOutLine,
    input  wire logic [1:0]  fmt,
    input  wire logic [3:0]  sizeM1,
    input  wire logic [15:0] reply,
    output logic             serialInLine,
    output logic [15:0]      got
);
    import ssf_pkg::*;
    int k = -20;
    initial serialInLine = 1'b0;
    // drive reply bit k, else invert the last level
    task automatic put();
        serialInLine = (k >= 0 && k <= int'(sizeM1) && (fmt == FMT_PULSE ||
            !frameSelectLine)) ? reply[int'(sizeM1) - k] : ~serialInLine;
    endtask
    // frame start: spi msb at once, control-word after byte and wait
    always @(negedge frameSelectLine) if (fmt != FMT_PULSE) begin
        k = (fmt == FMT_SPI) ? 0 : -9;
        put();
    end
    // reply bits launched on falling clock, pulse-sync captures there
    always @(negedge serialClockLine) begin
        if (fmt == FMT_PULSE) got = {got[14:0], serialOutLine};
        else if (!frameSelectLine) begin
            #1 k = (k == int'(sizeM1)) ? -9 : k + 1;
            put();
        end
    end
    // pulse-sync launches on rising clock, others capture there
    always @(posedge serialClockLine) begin
        #1 if (fmt == FMT_PULSE) k = frameSelectLine ? -1 : k + 1;
        if (fmt == FMT_PULSE) put();
        else got = {got[14:0], serialOutLine};
    end
    always @(posedge frameSelectLine) put();
endmodule

// file: dv/tb_top.sv
// self-checking bench of the frame formatter
`timescale 1ns/1ps
module tb_top;
    import ssf_pkg::*;
    typedef struct packed {
        logic        pha;
        logic [1:0]  fmt;
        logic [3:0]  m1;
        logic [15:0] tx;
        logic [15:0] rep;
    } ssf_row_t;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic serialTickClk = 1'b0;
    logic masterStrap = 1'b1;
    ssf_cfg_t portCfg = '0;
    logic txValid = 1'b0;
    logic [15:0] txData = '0;
    logic [15:0] reply = '0;
    logic txReady, rxValid, serialInLine, serialClockLine, serialClockLineOe;
    logic frameSelectLine, frameSelectLineOe, serialOutLine, serialOutLineOe;
    logic [15:0] rxData, got, mk;
    int err_total = 0;
    int compares = 0;
    ssf_row_t rows [7] = '{'{1'b0, FMT_SPI, 4'h7, 16'h00c3, 16'h005a},
        '{1'b0, FMT_SPI, 4'hf, 16'ha5f0, 16'h3c96},
        '{1'b1, FMT_SPI, 4'hb, 16'h0abc, 16'h0f35},
        '{1'b0, FMT_PULSE, 4'h3, 16'h0009, 16'h0006},
        '{1'b0, FMT_PULSE, 4'hf, 16'h1234, 16'hedcb},
        '{1'b0, FMT_CTRL, 4'h3, 16'h00a1, 16'h000b},
        '{1'b0, FMT_CTRL, 4'hf, 16'h0055, 16'h8e71}};
    ssf_port ssf_port_inst (.clk_sys, .rstn, .serialTickClk, .masterStrap,
        .portCfg, .txValid, .txData, .txReady, .rxValid, .rxData,
        .serialInLine, .serialClockLine, .serialClockLineOe,
        .frameSelectLine, .frameSelectLineOe, .serialOutLine,
        .serialOutLineOe);
    ssf_slave_model ssf_slave_model_inst (.serialClockLine, .frameSelectLine,
        .serialOutLine, .fmt(portCfg.frameFormat),
        .sizeM1(portCfg.dataSizeM1), .reply, .serialInLine, .got);
    // ****************************************************************
    // clocks, checks and closing
    // ****************************************************************
    always #25 clk_sys = ~clk_sys;
    initial begin
        #1.3;
        forever #3 serialTickClk = ~serialTickClk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d, comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // hand one word over when the slot is free
    task automatic send(input logic [15:0] w);
        int n;
        n = 0;
        @(posedge clk_sys);
        while (txReady !== 1'b1 && n < 99) begin
            @(posedge clk_sys);
            n++;
        end
        if (txReady !== 1'b1) err_total++;
        txData <= w;
        txValid <= 1'b1;
        @(posedge clk_sys);
        txValid <= 1'b0;
    endtask
    task automatic waitRx();
        int n;
        n = 0;
        @(posedge clk_sys);
        while (rxValid !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        if (rxValid !== 1'b1) err_total++;
    endtask
    // idle pins: clock, frame, driven data, data enable
    task automatic idle(input logic [1:0] f, input logic pol,
                        input logic [15:0] e);
        @(posedge clk_sys);
        portCfg <= '{1'b1, f, pol, 1'b0, 4'h7};
        repeat (4) @(posedge clk_sys);
        chk({serialClockLine, frameSelectLine,
            serialOutLine & serialOutLineOe, serialOutLineOe}, e);
    endtask
    initial begin
        #200000;
        err_total++;
        test_done();
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge clk_sys);
        chk({txReady, rxValid, serialClockLineOe, frameSelectLineOe,
            serialOutLineOe}, 16'h0);
        rstn <= 1'b1;
        idle(FMT_SPI, 1'b0, 16'h5);
        idle(FMT_SPI, 1'b1, 16'hd);
        idle(FMT_PULSE, 1'b0, 16'h0);
        idle(FMT_CTRL, 1'b0, 16'h5);
        foreach (rows[i]) begin
            @(posedge clk_sys);
            portCfg <= '{1'b0, rows[i].fmt, 1'b0, rows[i].pha, rows[i].m1};
            reply <= rows[i].rep;
            send(rows[i].tx);
            chk(16'(serialOutLineOe), 16'h0);
            portCfg.portEnableBit <= 1'b1;
            waitRx();
            mk = (16'h1 << (rows[i].m1 + 5'h1)) - 16'h1;
            chk(rxData, rows[i].rep & mk);
            if (rows[i].fmt != FMT_CTRL)
                chk(got & mk, rows[i].tx & mk);
            else if (rows[i].m1 < 4'h7)
                chk(16'((got >> (rows[i].m1 + 5'h2)) & 16'hff),
                    rows[i].tx & 16'hff);
        end
        // word written while the port is already enabled
        @(posedge clk_sys);
        portCfg <= '{1'b0, FMT_SPI, 1'b0, 1'b0, 4'h7};
        reply <= 16'h0096;
        @(posedge clk_sys);
        portCfg.portEnableBit <= 1'b1;
        repeat (4) @(posedge clk_sys);
        send(16'h005c);
        waitRx();
        chk(rxData, 16'h0096);
        chk(got & 16'h00ff, 16'h005c);
        // reset in mid-run, then role and slot come back
        rstn <= 1'b0;
        @(posedge clk_sys);
        chk({txReady, rxValid, serialClockLineOe, frameSelectLineOe,
            serialOutLineOe}, 16'h0);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({txReady, serialClockLineOe, frameSelectLineOe}, 16'h7);
        test_done();
    end
endmodule

// file: rtl/ssf_pkg.sv
// constants and types of the synchronous serial frame formatter
package ssf_pkg;

    // ****************************************************************
    // word and field sizes
    // ****************************************************************
    localparam int unsigned WORD_W   = 16;
    localparam logic [3:0]  SIZE_MIN = 4'h3;   // smallest size code, 4 bits
    localparam logic [3:0]  MSB_IDX  = 4'hf;   // shifter msb position
    localparam logic [4:0]  CTRL_LAST = 5'h07; // index of last control bit

    // ****************************************************************
    // frame format codes
    // ****************************************************************
    localparam logic [1:0] FMT_SPI   = 2'h0;
    localparam logic [1:0] FMT_PULSE = 2'h1; // pulse_sync_format
    localparam logic [1:0] FMT_CTRL  = 2'h2; // control-word format

    // ****************************************************************
    // link sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_PRE   = 3'b001,
        ST_SYNC  = 3'b010,
        ST_SHIFT = 3'b011,
        ST_TURN  = 3'b100,
        ST_RESP  = 3'b101,
        ST_TAIL  = 3'b110
    } ssf_state_t;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic       portEnableBit;
        logic [1:0] frameFormat;
        logic       clkPolarity;
        logic       clkPhase;
        logic [3:0] dataSizeM1;
    } ssf_cfg_t;

    typedef struct packed {
        logic clk;
        logic clkOe;
        logic frame;
        logic frameOe;
        logic dout;
        logic doutOe;
    } ssf_pins_t;

    // link domain state
    typedef struct packed {
        ssf_cfg_t    cfgS1;
        ssf_cfg_t    cfgS2;
        logic        roleS1;
        logic        roleS2;
        logic        reqS1;
        logic        reqS2;
        logic        rxAckS1;
        logic        rxAckS2;
        logic        dinS1;
        logic        dinS2;
        ssf_state_t  state;
        logic        half;
        logic [4:0]  cnt;
        logic [15:0] txSh;
        logic [15:0] rxSh;
        logic [15:0] rxWord;
        logic        rxTgl;
        logic        txAck;
        logic [1:0]  capPipe;
        logic [2:0]  pushPipe;
        ssf_pins_t   pins;
    } ssf_link_t;

    // system domain state
    typedef struct packed {
        logic        role;
        logic        roleDone;
        logic [15:0] txHold;
        logic        reqTgl;
        logic        txReady;
        logic        ackS1;
        logic        ackS2;
        logic        rxS1;
        logic        rxS2;
        logic        rxS3;
        logic        rxAckTgl;
        logic        rxValid;
        logic [15:0] rxData;
    } ssf_sys_t;

    // values after reset
    localparam ssf_link_t LINK_RST = '0;
    localparam ssf_sys_t  SYS_RST  = '0;

endpackage

// file: rtl/ssf_port.sv
// frame formatter of the synchronous serial port, master side
`timescale 1ns/1ps
module ssf_port (
    input  wire logic            clk_sys,
    input  wire logic            rstn,
    input  wire logic            serialTickClk,
    input  wire logic            masterStrap,
    input  wire ssf_pkg::ssf_cfg_t portCfg,
    input  wire logic            txValid,
    input  wire logic [15:0]     txData,
    output logic                 txReady,
    output logic                 rxValid,
    output logic [15:0]          rxData,
    input  wire logic            serialInLine,
    output logic                 serialClockLine,
    output logic                 serialClockLineOe,
    output logic                 frameSelectLine,
    output logic                 frameSelectLineOe,
    output logic                 serialOutLine,
    output logic                 serialOutLineOe
);
    import ssf_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // size code with the lower bound applied
    function automatic logic [3:0] sizeM1(input logic [3:0] code);
        sizeM1 = (code < SIZE_MIN) ? SIZE_MIN : code;
    endfunction

    // move a word so that its msb sits at the shifter top
    function automatic logic [15:0] alignMsb(input logic [15:0] w,
                                             input logic [3:0]  m1);
        alignMsb = 16'(w << (MSB_IDX - m1));
    endfunction

    // keep only the bits of the programmed size
    function automatic logic [15:0] maskWord(input logic [15:0] w,
                                             input logic [3:0]  m1);
        maskWord = w & ~(16'(16'hfffe << m1));
    endfunction

    ssf_sys_t  s_q, s_d;
    ssf_link_t l_q, l_d;

    // ****************************************************************
    // system domain: word hand-off and role strap
    // ****************************************************************
    // next state of the system side
    always_comb begin
        s_d         = s_q;
        s_d.ackS1   = l_q.txAck;
        s_d.ackS2   = s_q.ackS1;
        s_d.rxS1    = l_q.rxTgl;
        s_d.rxS2    = s_q.rxS1;
        s_d.rxS3    = s_q.rxS2;
        s_d.rxValid = 1'b0;
        // role caught once after reset release
        if (!s_q.roleDone) begin
            s_d.role     = masterStrap;
            s_d.roleDone = 1'b1;
        end
        // a write makes a word pending for the link
        if (s_q.txReady && txValid) begin
            s_d.txHold  = txData;
            s_d.reqTgl  = ~s_q.reqTgl;
            s_d.txReady = 1'b0;
        end else begin
            s_d.txReady = (s_q.ackS2 == s_q.reqTgl);
        end
        // received word arrives, take it and acknowledge
        if (s_q.rxS2 != s_q.rxS3) begin
            s_d.rxValid  = 1'b1;
            s_d.rxData   = l_q.rxWord;
            s_d.rxAckTgl = s_q.rxS2;
        end
    end

    // system side registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q <= SYS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // link domain: frame sequencer, one tick per half bit
    // ****************************************************************
    ssf_cfg_t    c;
    logic [3:0]  m1;
    logic [4:0]  lastIdx;
    logic        last;
    logic        canStart;
    logic        goStart;
    logic        rxFree;

    // next state of the link side
    always_comb begin
        l_d          = l_q;
        c            = l_q.cfgS2;
        m1           = sizeM1(c.dataSizeM1);
        lastIdx      = (l_q.state == ST_SHIFT && c.frameFormat == FMT_CTRL)
                       ? CTRL_LAST : {1'b0, m1};
        last         = (l_q.cnt == lastIdx);
        rxFree       = (l_q.rxTgl == l_q.rxAckS2);
        canStart     = c.portEnableBit && l_q.roleS2 &&
                       (l_q.reqS2 != l_q.txAck) && rxFree;
        goStart      = 1'b0;
        // crossings
        l_d.cfgS1    = portCfg;
        l_d.cfgS2    = l_q.cfgS1;
        l_d.roleS1   = s_q.role && s_q.roleDone;
        l_d.roleS2   = l_q.roleS1;
        l_d.reqS1    = s_q.reqTgl;
        l_d.reqS2    = l_q.reqS1;
        l_d.rxAckS1  = s_q.rxAckTgl;
        l_d.rxAckS2  = l_q.rxAckS1;
        l_d.dinS1    = serialInLine;
        l_d.dinS2    = l_q.dinS1;
        l_d.capPipe  = {l_q.capPipe[0], 1'b0};
        l_d.pushPipe = {l_q.pushPipe[1:0], 1'b0};
        // delayed capture, aligned to the synchronised input
        if (l_q.capPipe[1]) begin
            l_d.rxSh = {l_q.rxSh[14:0], l_q.dinS2};
        end
        // delayed push; a word is dropped if the slot is still full
        if (l_q.pushPipe[2] && rxFree) begin
            l_d.rxWord = maskWord(l_q.rxSh, m1);
            l_d.rxTgl  = ~l_q.rxTgl;
        end
        l_d.pins.clkOe   = l_q.roleS2;
        l_d.pins.frameOe = l_q.roleS2;
        case (l_q.state)
            ST_IDLE: begin
                goStart = 1'b1;
            end
            ST_SYNC: begin
                l_d.pins.clk = 1'b0;
                l_d.state    = ST_SHIFT;
                l_d.half     = 1'b0;
                l_d.cnt      = 5'h00;
            end
            ST_PRE: begin
                // phase zero shows the msb half a period early
                if (!c.clkPhase) begin
                    l_d.pins.dout = l_q.txSh[15];
                    l_d.txSh      = {l_q.txSh[14:0], 1'b0};
                end
                l_d.state = ST_SHIFT;
                l_d.half  = 1'b0;
            end
            ST_SHIFT, ST_RESP: begin
                l_d.half = ~l_q.half;
                if (!l_q.half) begin
                    // leading edge
                    if (c.frameFormat == FMT_PULSE) begin
                        l_d.pins.clk   = 1'b1;
                        l_d.pins.frame = 1'b0;
                        l_d.pins.dout  = l_q.txSh[15];
                        l_d.txSh       = {l_q.txSh[14:0], 1'b0};
                    end else if (c.frameFormat == FMT_SPI) begin
                        l_d.pins.clk = ~c.clkPolarity;
                        if (!c.clkPhase) begin
                            l_d.capPipe[0] = 1'b1;
                        end else begin
                            l_d.pins.dout = l_q.txSh[15];
                            l_d.txSh      = {l_q.txSh[14:0], 1'b0};
                        end
                    end else begin
                        l_d.pins.clk = 1'b1;
                        // reply sampled on rising, none during control
                        l_d.capPipe[0] = (l_q.state == ST_RESP);
                    end
                end else begin
                    // trailing edge
                    if (!last) begin
                        l_d.cnt = 5'(l_q.cnt + 5'h01);
                    end
                    if (c.frameFormat == FMT_PULSE) begin
                        l_d.pins.clk   = 1'b0;
                        l_d.capPipe[0] = 1'b1;
                        if (last) begin
                            l_d.state = ST_TAIL;
                        end
                    end else if (c.frameFormat == FMT_SPI) begin
                        l_d.pins.clk = c.clkPolarity;
                        if (c.clkPhase) begin
                            l_d.capPipe[0] = 1'b1;
                        end else if (!last) begin
                            l_d.pins.dout = l_q.txSh[15];
                            l_d.txSh      = {l_q.txSh[14:0], 1'b0};
                        end
                        if (last && c.clkPhase && canStart) begin
                            // phase one keeps the frame low between words
                            l_d.pushPipe[0] = 1'b1;
                            l_d.txAck       = l_q.reqS2;
                            l_d.txSh        = alignMsb(s_q.txHold, m1);
                            l_d.cnt         = 5'h00;
                        end else if (last) begin
                            l_d.state = ST_TAIL;
                            l_d.half  = 1'b0;
                        end
                    end else begin
                        l_d.pins.clk = 1'b0;
                        if (l_q.state == ST_SHIFT) begin
                            // control bits change on falling edges
                            l_d.pins.dout = last ? 1'b0 : l_q.txSh[15];
                            l_d.txSh      = {l_q.txSh[14:0], 1'b0};
                            if (last) begin
                                l_d.state = ST_TURN;
                            end
                        end else if (last && canStart) begin
                            // next control byte right after the lsb
                            l_d.pushPipe[0] = 1'b1;
                            l_d.txAck       = l_q.reqS2;
                            l_d.pins.dout   = s_q.txHold[7];
                            l_d.txSh        = {s_q.txHold[6:0], 9'h000};
                            l_d.state       = ST_SHIFT;
                            l_d.cnt         = 5'h00;
                        end else if (last) begin
                            l_d.state = ST_TAIL;
                        end
                    end
                end
            end
            ST_TURN: begin
                // one idle clock while the slave decodes
                l_d.pins.clk = ~l_q.half;
                l_d.half     = ~l_q.half;
                if (l_q.half) begin
                    l_d.state = ST_RESP;
                    l_d.cnt   = 5'h00;
                end
            end
            ST_TAIL: begin
                if (c.frameFormat == FMT_PULSE) begin
                    l_d.pushPipe[0] = 1'b1;
                    goStart         = 1'b1;
                end else if (c.frameFormat == FMT_SPI && c.clkPhase &&
                             !l_q.half) begin
                    l_d.half = 1'b1;
                end else begin
                    l_d.pins.frame  = 1'b1;
                    l_d.pushPipe[0] = 1'b1;
                    l_d.state       = ST_IDLE;
                end
            end
            default: begin
                l_d.state = ST_IDLE;
            end
        endcase
        // start of a word, or the idle levels of each format
        if (goStart && canStart) begin
            l_d.txAck       = l_q.reqS2;
            l_d.half        = 1'b0;
            l_d.cnt         = 5'h00;
            l_d.pins.doutOe = 1'b1;
            if (c.frameFormat == FMT_PULSE) begin
                l_d.pins.clk   = 1'b1;
                l_d.pins.frame = 1'b1;
                l_d.txSh       = alignMsb(s_q.txHold, m1);
                l_d.state      = ST_SYNC;
            end else if (c.frameFormat == FMT_SPI) begin
                l_d.pins.frame = 1'b0;
                l_d.txSh       = alignMsb(s_q.txHold, m1);
                l_d.state      = ST_PRE;
            end else begin
                l_d.pins.frame = 1'b0;
                l_d.pins.dout  = s_q.txHold[7];
                l_d.txSh       = {s_q.txHold[6:0], 9'h000};
                l_d.state      = ST_SHIFT;
            end
        end else if (goStart) begin
            l_d.state       = ST_IDLE;
            l_d.pins.dout   = 1'b0;
            l_d.pins.doutOe = c.portEnableBit && l_q.roleS2 &&
                              (c.frameFormat != FMT_PULSE);
            l_d.pins.clk    = (c.frameFormat == FMT_SPI) &&
                              c.clkPolarity;
            l_d.pins.frame  = (c.frameFormat != FMT_PULSE);
        end
        // disabled or slave: abort and release the data driver
        if (!c.portEnableBit || !l_q.roleS2) begin
            l_d.state       = ST_IDLE;
            l_d.pins.doutOe = 1'b0;
        end
    end

    // link side registers
    always_ff @(posedge serialTickClk or negedge rstn) begin
        if (!rstn) begin
            l_q <= LINK_RST;
        end else begin
            l_q <= l_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign txReady           = s_q.txReady;
    assign rxValid           = s_q.rxValid;
    assign rxData            = s_q.rxData;
    assign serialClockLine   = l_q.pins.clk;
    assign serialClockLineOe = l_q.pins.clkOe;
    assign frameSelectLine   = l_q.pins.frame;
    assign frameSelectLineOe = l_q.pins.frameOe;
    assign serialOutLine     = l_q.pins.dout;
    assign serialOutLineOe   = l_q.pins.doutOe;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic enOn;
    assign enOn = l_q.cfgS2.portEnableBit && l_q.roleS2;

    AST_SYNC_ONE_BIT: assert property (
        @(posedge serialTickClk) disable iff (!rstn)
        enOn && c.frameFormat == FMT_PULSE && $rose(l_q.pins.frame)
        |-> l_q.pins.frame ##1 l_q.pins.frame ##1 !l_q.pins.frame)
        else $error("pulse frame not one bit long");

    AST_PULSE_CAP_FALL: assert property (
        @(posedge serialTickClk) disable iff (!rstn)
        enOn && c.frameFormat == FMT_PULSE && l_q.capPipe[0]
        |-> !l_q.pins.clk && $past(l_q.pins.clk))
        else $error("pulse sample not on falling edge");

    AST_PULSE_PUSH: assert property (
        @(posedge serialTickClk) disable iff (!rstn)
        enOn && c.frameFormat == FMT_PULSE && l_q.pushPipe[0]
        |-> $past(l_q.capPipe[0]))
        else $error("pulse push not one edge after lsb");

    AST_FRAME_LOW: assert property (
        @(posedge serialTickClk) disable iff (!rstn)
        enOn && c.frameFormat != FMT_PULSE &&
        (l_q.state inside {ST_PRE, ST_SHIFT, ST_TURN, ST_RESP})
        |-> !l_q.pins.frame)
        else $error("frame high during transfer");

    AST_SPI_IDLE: assert property (
        @(posedge serialTickClk) disable iff (!rstn)
        enOn && c.frameFormat == FMT_SPI && $stable(c) &&
        l_q.state == ST_IDLE && $past(l_q.state) == ST_IDLE
        |-> l_q.pins.clk == c.clkPolarity && l_q.pins.frame &&
            !l_q.pins.dout)
        else $error("spi idle levels wrong");

    AST_SPI_CAP_EDGE: assert property (
        @(posedge serialTickClk) disable iff (!rstn)
        enOn && c.frameFormat == FMT_SPI && l_q.capPipe[0]
        |-> (l_q.pins.clk != c.clkPolarity) == !c.clkPhase)
        else $error("spi capture on wrong edge");

    AST_SPI_LEAD: assert property (
        @(posedge serialTickClk) disable iff (!rstn)
        enOn && c.frameFormat == FMT_SPI && !c.clkPhase &&
        $fell(l_q.pins.frame)
        |-> l_q.pins.clk == c.clkPolarity ##2
            l_q.pins.clk != c.clkPolarity)
        else $error("spi clock not two halves after frame");

    AST_SPI_FRAME_END: assert property (
        @(posedge serialTickClk) disable iff (!rstn)
        enOn && c.frameFormat == FMT_SPI && !c.clkPhase &&
        $stable(c) && $rose(l_q.pins.frame) && $past(l_q.state) != ST_IDLE
        |-> $past(l_q.capPipe[0], 2))
        else $error("spi frame end not one period after capture");

    AST_CTRL_NO_CAP: assert property (
        @(posedge serialTickClk) disable iff (!rstn)
        c.frameFormat == FMT_CTRL && l_q.state == ST_SHIFT
        |=> !l_q.capPipe[0])
        else $error("capture during control byte");

    AST_CTRL_LOAD: assert property (
        @(posedge serialTickClk) disable iff (!rstn)
        enOn && c.frameFormat == FMT_CTRL && $fell(l_q.pins.frame)
        |-> l_q.txAck != $past(l_q.txAck) && l_q.pins.doutOe)
        else $error("falling frame did not load a word");

    AST_TAIL_QUIET: assert property (
        @(posedge serialTickClk) disable iff (!rstn)
        enOn && c.frameFormat != FMT_PULSE && l_q.state == ST_TAIL
        |=> $stable(l_q.pins.clk))
        else $error("clock moved after the word");

    AST_RELEASE: assert property (
        @(posedge serialTickClk) disable iff (!rstn)
        !l_q.cfgS2.portEnableBit |=> !l_q.pins.doutOe)
        else $error("data driver on while disabled");

    AST_ROLE_FIXED: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        s_q.roleDone |=> $stable(s_q.role))
        else $error("role changed after reset");

    COV_PULSE_WORD: cover property (
        @(posedge serialTickClk) disable iff (!rstn)
        c.frameFormat == FMT_PULSE && l_q.pushPipe[0]);

    COV_SPI_GAP: cover property (
        @(posedge serialTickClk) disable iff (!rstn)
        c.frameFormat == FMT_SPI && $rose(l_q.pins.frame) ##1
        $fell(l_q.pins.frame));

    COV_CTRL_BACK: cover property (
        @(posedge serialTickClk) disable iff (!rstn)
        l_q.state == ST_RESP ##1 l_q.state == ST_SHIFT);

    COV_RX_WORD: cover property (
        @(posedge clk_sys) disable iff (!rstn) s_q.rxValid);
endmodule
